// File: design/ppc_port_ctrl.sv
// Purpose: pin control for ports 0, 1 and 2 with serial/uart routing
// Assumes: pins and peripheral signals are synchronous to pclk
// Notes:   APB answers after one wait state; pins follow writes at once
//
// Contract
// - each pin output latch keeps the last written value until rewritten
// - pin reads return the live level; nothing latches inputs
// - pin level sampled only in the read cycle of the access
// - written value appears on the pin in the cycle after the write
// - output mode drives the output data latch onto the pin
// - input mode read returns the pin's current logic level
// - direction bit 0 means input, 1 means output
// - secondary enable 1 routes peripheral output, 0 gives plain port
// - output type selects push-pull or open drain; open drain drives low
// - pull-up connects only in input mode or open-drain output
// - port 0 lowest two pins are dedicated to main oscillator
// - secondary enable on the sub oscillator input pin selects oscillator use
// - port 1 has no secondary enable; irq inputs need direction 0
// - port 2 route field places two-wire or sync serial pins
// - uart0 swap bit exchanges receive and transmit on pins 1, 0
`default_nettype none
module ppc_port_ctrl (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ppc_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [ppc_pkg::DATA_W-1:0]  pwdata,
   output var  logic [ppc_pkg::DATA_W-1:0]  prdata,
   output var  logic                        pready,
   output var  logic                        pslverr,
   input  wire logic [ppc_pkg::PIN_W-1:0]   pin_in,
   output var  logic [ppc_pkg::PIN_W-1:0]   pin_out,
   output var  logic [ppc_pkg::PIN_W-1:0]   pin_oe,
   output var  logic [ppc_pkg::PIN_W-1:0]   pin_pu,
   output var  logic                        main_osc_en,
   output var  logic                        sub_osc_en,
   output var  logic                        ext_irq_a,
   output var  logic                        ext_irq_b,
   output var  logic                        ext_irq_f,
   output var  logic                        stop_release,
   input  wire logic                        two_wire_clock_drv,
   input  wire logic                        two_wire_data_drv,
   output var  logic                        two_wire_clock,
   output var  logic                        two_wire_data,
   input  wire logic                        sync_serial_clock_drv,
   output var  logic                        sync_serial_clock,
   input  wire logic                        sync_serial_out,
   output var  logic                        sync_serial_in,
   input  wire logic                        uart0_transmit,
   output var  logic                        uart0_receive
);
   import ppc_pkg::*;

   // merge a bus write into a register value
   function automatic logic [7:0] merge8(input logic hit,
                                         input logic [DATA_W-1:0] wd,
                                         input logic [7:0] cur);
      return hit ? wd[7:0] : cur;
   endfunction

   function automatic logic [3:0] merge4(input logic hit,
                                         input logic [DATA_W-1:0] wd,
                                         input logic [3:0] cur);
      return hit ? wd[3:0] : cur;
   endfunction

   logic [P0_W-1:0] p0_data, p0_dir, p0_fc, p0_pu;
   logic [P1_W-1:0] p1_data, p1_dir, p1_pu;
   logic [P2_W-1:0] p2_data, p2_dir, p2_fc, p2_od, p2_pu;
   logic [2:0]      route;
   logic            uart_swap;
   logic [P0_W-1:0] next_p0_data, next_p0_dir, next_p0_fc, next_p0_pu;
   logic [P1_W-1:0] next_p1_data, next_p1_dir, next_p1_pu;
   logic [P2_W-1:0] next_p2_data, next_p2_dir, next_p2_fc;
   logic [P2_W-1:0] next_p2_od, next_p2_pu;
   logic [2:0]      next_route;
   logic            next_uart_swap;
   logic            wr_en, rd_take, rd_err;
   logic [DATA_W-1:0] rd_val;

   // bus decode: writes land on the edge that completes the access
   assign wr_en   = psel & penable & pready & pwrite;
   assign rd_take = psel & penable & ~pready;

   // register next values
   assign next_p0_data = merge4(wr_en && paddr == OFF_P0_DATA, pwdata,
                                p0_data);
   assign next_p0_dir  = merge4(wr_en && paddr == OFF_P0_DIR, pwdata,
                                p0_dir);
   assign next_p0_fc   = merge4(wr_en && paddr == OFF_P0_FC, pwdata,
                                p0_fc) & P0_FC_MASK;
   assign next_p0_pu   = merge4(wr_en && paddr == OFF_P0_PU, pwdata, p0_pu);
   assign next_p1_data = merge4(wr_en && paddr == OFF_P1_DATA, pwdata,
                                p1_data);
   assign next_p1_dir  = merge4(wr_en && paddr == OFF_P1_DIR, pwdata,
                                p1_dir);
   assign next_p1_pu   = merge4(wr_en && paddr == OFF_P1_PU, pwdata, p1_pu);
   assign next_p2_data = merge8(wr_en && paddr == OFF_P2_DATA, pwdata,
                                p2_data);
   assign next_p2_dir  = merge8(wr_en && paddr == OFF_P2_DIR, pwdata,
                                p2_dir);
   assign next_p2_fc   = merge8(wr_en && paddr == OFF_P2_FC, pwdata, p2_fc);
   assign next_p2_od   = merge8(wr_en && paddr == OFF_P2_OD, pwdata, p2_od);
   assign next_p2_pu   = merge8(wr_en && paddr == OFF_P2_PU, pwdata, p2_pu);
   assign next_route   = (wr_en && paddr == OFF_ROUTE) ? pwdata[2:0] : route;
   assign next_uart_swap = (wr_en && paddr == OFF_UART_CFG) ? pwdata[0]
                                                           : uart_swap;

   // control registers; reset leaves every pin an undriven input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {p0_data, p0_dir, p0_fc, p0_pu} <= {4{RST_PORT[P0_W-1:0]}};
         {p1_data, p1_dir, p1_pu}        <= {3{RST_PORT[P1_W-1:0]}};
         {p2_data, p2_dir, p2_fc, p2_od, p2_pu} <= {5{RST_PORT}};
         route     <= RST_ROUTE;
         uart_swap <= 1'b0;
      end else begin
         p0_data   <= next_p0_data;
         p0_dir    <= next_p0_dir;
         p0_fc     <= next_p0_fc;
         p0_pu     <= next_p0_pu;
         p1_data   <= next_p1_data;
         p1_dir    <= next_p1_dir;
         p1_pu     <= next_p1_pu;
         p2_data   <= next_p2_data;
         p2_dir    <= next_p2_dir;
         p2_fc     <= next_p2_fc;
         p2_od     <= next_p2_od;
         p2_pu     <= next_p2_pu;
         route     <= next_route;
         uart_swap <= next_uart_swap;
      end
   end

   // read mux; pin reads see the live pin, never a stored copy
   always_comb begin
      rd_val = '0;
      rd_err = 1'b0;
      case (paddr)
         OFF_P0_DATA:  rd_val[P0_W-1:0] = p0_data;
         OFF_P0_READ:  rd_val[P0_W-1:0] = pin_in[P0_BASE +: P0_W];
         OFF_P0_DIR:   rd_val[P0_W-1:0] = p0_dir;
         OFF_P0_FC:    rd_val[P0_W-1:0] = p0_fc;
         OFF_P0_PU:    rd_val[P0_W-1:0] = p0_pu;
         OFF_P1_DATA:  rd_val[P1_W-1:0] = p1_data;
         OFF_P1_READ:  rd_val[P1_W-1:0] = pin_in[P1_BASE +: P1_W];
         OFF_P1_DIR:   rd_val[P1_W-1:0] = p1_dir;
         OFF_P1_PU:    rd_val[P1_W-1:0] = p1_pu;
         OFF_P2_DATA:  rd_val[P2_W-1:0] = p2_data;
         OFF_P2_READ:  rd_val[P2_W-1:0] = pin_in[P2_BASE +: P2_W];
         OFF_P2_DIR:   rd_val[P2_W-1:0] = p2_dir;
         OFF_P2_FC:    rd_val[P2_W-1:0] = p2_fc;
         OFF_P2_OD:    rd_val[P2_W-1:0] = p2_od;
         OFF_P2_PU:    rd_val[P2_W-1:0] = p2_pu;
         OFF_ROUTE:    rd_val[2:0]      = route;
         OFF_UART_CFG: rd_val[0]        = uart_swap;
         default:      rd_err           = 1'b1;
      endcase
   end

   // one wait state so every bus output comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= rd_take;
         prdata  <= (rd_take && !pwrite) ? rd_val : '0;
         pslverr <= rd_take & rd_err;
      end
   end

   // port 2 routing, decoded from the value the pins will show
   logic tw_on, ss_hi, ss_lo, ua_on;
   logic [P2_W-1:0] p2_alt;
   logic [P2_W-1:0] p2_od_force;
   assign tw_on = ~next_route[0];
   assign ss_hi = next_route[1:0] == ROUTE_SS_HI;
   assign ss_lo = next_route[1:0] == ROUTE_SS_LO && !next_route[ROUTE_GRP_BIT];
   assign ua_on = ~next_route[1] & ~next_route[ROUTE_GRP_BIT];

   // idle-high default keeps unrouted secondary outputs quiet
   assign p2_alt[7:6] = 2'h3;
   assign p2_alt[P2_SSH_CLK] = ss_hi ? sync_serial_clock_drv : 1'b1;
   assign p2_alt[P2_TW_CLK]  = tw_on ? two_wire_clock_drv : 1'b1;
   assign p2_alt[P2_TW_DAT]  = tw_on ? two_wire_data_drv
                             : ss_hi ? sync_serial_out : 1'b1;
   assign p2_alt[P2_SSL_CLK] = ss_lo ? sync_serial_clock_drv : 1'b1;
   assign p2_alt[P2_UART_A]  = (ua_on && next_uart_swap) ? uart0_transmit
                             : 1'b1;
   assign p2_alt[P2_UART_B]  = ss_lo ? sync_serial_out
                             : (ua_on && !next_uart_swap) ? uart0_transmit
                             : 1'b1;
   // two-wire pins are open drain whatever the type select says
   assign p2_od_force = tw_on ? ((8'h1 << P2_TW_CLK) | (8'h1 << P2_TW_DAT))
                              : 8'h0;

   // per-pin controls gathered into the pin vector
   logic [PIN_W-1:0] cell_dir, cell_data, cell_alt, cell_fc;
   logic [PIN_W-1:0] cell_od, cell_pu, cell_osc;
   logic [P0_W-1:0]  p0_osc;
   assign p0_osc = {next_p0_fc[P0_SUB_IN], next_p0_fc[P0_SUB_IN],
                    2'h3};
   assign cell_dir  = {next_p2_dir, next_p1_dir, next_p0_dir};
   assign cell_data = {next_p2_data, next_p1_data, next_p0_data};
   assign cell_alt  = {p2_alt, 8'hff};
   // port 1 has neither secondary enable nor type select
   assign cell_fc   = {next_p2_fc, 8'h0};
   assign cell_od   = {next_p2_od | p2_od_force, 8'h0};
   assign cell_pu   = {next_p2_pu, next_p1_pu, next_p0_pu};
   assign cell_osc  = {8'h0, 4'h0, p0_osc};

   // pin drive stages; registered from next values so holds
   for (genvar i = 0; i < PIN_W; i++) begin : g_pin
      ppc_pin_cell u_cell (
         .pclk    (pclk),
         .presetn (presetn),
         .dir     (cell_dir[i]),
         .data    (cell_data[i]),
         .alt     (cell_alt[i]),
         .fc      (cell_fc[i]),
         .od      (cell_od[i]),
         .pu_sel  (cell_pu[i]),
         .osc     (cell_osc[i]),
         .pad_out (pin_out[i]),
         .pad_oe  (pin_oe[i]),
         .pad_pu  (pin_pu[i])
      );
   end

   // peripheral inputs; irq pins only listen while set as inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {main_osc_en, sub_osc_en, ext_irq_a} <= 3'h0;
         {ext_irq_b, ext_irq_f, stop_release} <= 3'h0;
         {two_wire_clock, two_wire_data, sync_serial_clock} <= 3'h7;
         {sync_serial_in, uart0_receive}      <= 2'h3;
      end else begin
         main_osc_en  <= 1'b1;
         sub_osc_en   <= p0_fc[P0_SUB_IN];
         ext_irq_a    <= ~p1_dir[P1_IRQ_A] & pin_in[P1_BASE + P1_IRQ_A];
         ext_irq_b    <= ~p1_dir[P1_IRQ_B] & pin_in[P1_BASE + P1_IRQ_B];
         ext_irq_f    <= ~p1_dir[P1_IRQ_F] & pin_in[P1_BASE + P1_IRQ_F];
         stop_release <= ~p1_dir[P1_IRQ_F] & pin_in[P1_BASE + P1_IRQ_F];
         two_wire_clock <= ~route[0] ? pin_in[P2_BASE + P2_TW_CLK] : 1'b1;
         two_wire_data  <= ~route[0] ? pin_in[P2_BASE + P2_TW_DAT] : 1'b1;
         sync_serial_clock <= ss_hi ? pin_in[P2_BASE + P2_SSH_CLK]
                            : ss_lo ? pin_in[P2_BASE + P2_SSL_CLK] : 1'b1;
         sync_serial_in <= ss_hi ? pin_in[P2_BASE + P2_SSH_IN]
                         : ss_lo ? pin_in[P2_BASE + P2_SSL_IN] : 1'b1;
         uart0_receive <= ~ua_on ? 1'b1
                        : uart_swap ? pin_in[P2_BASE + P2_UART_B]
                        : pin_in[P2_BASE + P2_UART_A];
      end
   end

   // helper: low until the first edge after reset release
   logic seen_edge;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) seen_edge <= 1'b0;
      else          seen_edge <= 1'b1;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_latch_hold;
      !(wr_en && paddr == OFF_P2_DATA) |=> $stable(p2_data);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("port data latch changed without a write");
   property p_pin_read;
      rd_take && !pwrite && paddr == OFF_P2_READ
         |=> pready && prdata[P2_W-1:0] == $past(pin_in[P2_BASE +: P2_W]);
   endproperty
   a_pin_read: assert property (p_pin_read)
      else $error("pin read did not return level of read cycle");
   property p_write_to_pin;
      wr_en && paddr == OFF_P2_DATA && p2_fc == 8'h0 && p2_dir == 8'hff
         && p2_od == 8'h0 && !route[0] == 1'b0
         |=> pin_out[P2_BASE +: P2_W] == $past(pwdata[P2_W-1:0])
             && pin_oe[P2_BASE +: P2_W] == 8'hff;
   endproperty
   a_write_to_pin: assert property (p_write_to_pin)
      else $error("written value not on pins the next cycle");
   property p_dir_input;
      p2_dir == 8'h0 |-> pin_oe[P2_BASE +: P2_W] == 8'h0;
   endproperty
   a_dir_input: assert property (p_dir_input)
      else $error("input pin is driven");
   property p_open_drain;
      (pin_oe[P2_BASE +: P2_W] & pin_out[P2_BASE +: P2_W] & p2_od) == 8'h0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open drain pin drives high");
   property p_pullup;
      // pads took the force decoded one edge earlier
      pin_pu[P2_BASE +: P2_W]
         == (p2_pu & (~p2_dir | p2_od | $past(p2_od_force)));
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-up connected in push-pull output");
   property p_main_osc;
      pin_oe[P0_MAIN_OUT:P0_MAIN_IN] == 2'h0 && pin_pu[1:0] == 2'h0;
   endproperty
   a_main_osc: assert property (p_main_osc)
      else $error("main oscillator pin used as port");
   property p_sub_osc;
      p0_fc[P0_SUB_IN] |-> pin_oe[P0_SUB_OUT:P0_SUB_IN] == 2'h0;
   endproperty
   a_sub_osc: assert property (p_sub_osc)
      else $error("sub oscillator pins driven as port");
   property p_irq_input;
      !p1_dir[P1_IRQ_A] |=> ext_irq_a == $past(pin_in[P1_BASE + P1_IRQ_A]);
   endproperty
   a_irq_input: assert property (p_irq_input)
      else $error("irq input not following its pin");
   property p_two_wire_od;
      !route[0] |-> !(pin_oe[P2_BASE + P2_TW_CLK]
                      && pin_out[P2_BASE + P2_TW_CLK]);
   endproperty
   a_two_wire_od: assert property (p_two_wire_od)
      else $error("two-wire clock pin driven high");
   property p_uart_tx;
      ua_on && !next_uart_swap && next_p2_fc[P2_UART_B] && !ss_lo
         |=> pin_out[P2_BASE + P2_UART_B] == $past(uart0_transmit);
   endproperty
   a_uart_tx: assert property (p_uart_tx)
      else $error("uart transmit not on its pin");
   property p_reset_idle;
      !seen_edge |-> pin_oe == '0;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("pin driven right after reset");
endmodule
`default_nettype wire

// File: design/ppc_pkg.sv
// Purpose: shared constants for the parallel port pin control block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   pin vector packs port 0 in bits 3:0, port 1 in 7:4, port 2 in 15:8
`default_nettype none
package ppc_pkg;
   // widths
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int P0_W    = 4;
   localparam int P1_W    = 4;
   localparam int P2_W    = 8;
   localparam int PIN_W   = 16;
   // bases of each port in the pin vector
   localparam int P0_BASE = 0;
   localparam int P1_BASE = 4;
   localparam int P2_BASE = 8;
   // register byte offsets
   localparam logic [7:0] OFF_P0_DATA  = 8'h00;
   localparam logic [7:0] OFF_P0_READ  = 8'h04;
   localparam logic [7:0] OFF_P0_DIR   = 8'h08;
   localparam logic [7:0] OFF_P0_FC    = 8'h0c;
   localparam logic [7:0] OFF_P1_DATA  = 8'h10;
   localparam logic [7:0] OFF_P1_READ  = 8'h14;
   localparam logic [7:0] OFF_P1_DIR   = 8'h18;
   localparam logic [7:0] OFF_P1_PU    = 8'h1c;
   localparam logic [7:0] OFF_P2_DATA  = 8'h20;
   localparam logic [7:0] OFF_P2_READ  = 8'h24;
   localparam logic [7:0] OFF_P2_DIR   = 8'h28;
   localparam logic [7:0] OFF_P2_FC    = 8'h2c;
   localparam logic [7:0] OFF_P2_OD    = 8'h30;
   localparam logic [7:0] OFF_P2_PU    = 8'h34;
   localparam logic [7:0] OFF_P0_PU    = 8'h38;
   localparam logic [7:0] OFF_ROUTE    = 8'h3c;
   localparam logic [7:0] OFF_UART_CFG = 8'h40;
   // reset values: all input, no secondary output, no pull-up
   localparam logic [7:0] RST_PORT     = 8'h00;
   localparam logic [2:0] RST_ROUTE    = 3'h0;
   // only oscillator input pins carry a secondary-function bit on port 0
   localparam logic [3:0] P0_FC_MASK   = 4'h5;
   // port 0 pin positions
   localparam int P0_MAIN_IN  = 0;
   localparam int P0_MAIN_OUT = 1;
   localparam int P0_SUB_IN   = 2;
   localparam int P0_SUB_OUT  = 3;
   // port 1 pin positions
   localparam int P1_IRQ_F    = 1;
   localparam int P1_IRQ_A    = 2;
   localparam int P1_IRQ_B    = 3;
   // port 2 pin positions
   localparam int P2_TW_CLK   = 4;
   localparam int P2_TW_DAT   = 3;
   localparam int P2_SSH_CLK  = 5;
   localparam int P2_SSH_IN   = 4;
   localparam int P2_SSH_OUT  = 3;
   localparam int P2_SSL_CLK  = 2;
   localparam int P2_SSL_IN   = 1;
   localparam int P2_SSL_OUT  = 0;
   localparam int P2_UART_A   = 1;
   localparam int P2_UART_B   = 0;
   // route register fields and codes
   localparam int ROUTE_GRP_BIT = 2;
   localparam logic [1:0] ROUTE_SS_HI = 2'h1;
   localparam logic [1:0] ROUTE_SS_LO = 2'h2;
endpackage
`default_nettype wire

// File: design/ppc_pin_cell.sv
// Purpose: drive stage of one pin: value, enable and pull-up flops
// Assumes: inputs are next-state register values, so the pad follows
//          a write at the same edge as the register itself
// Notes:   no tristate here; the pad wire is resolved outside
`default_nettype none
module ppc_pin_cell (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic dir,
   input  wire logic data,
   input  wire logic alt,
   input  wire logic fc,
   input  wire logic od,
   input  wire logic pu_sel,
   input  wire logic osc,
   output var  logic pad_out,
   output var  logic pad_oe,
   output var  logic pad_pu
);
   logic value;
   logic drive;
   logic next_oe;
   logic next_pu;

   // peripheral output replaces the latch only when selected
   assign value   = fc ? alt : data;
   // oscillator pins ignore direction entirely
   assign drive   = dir & ~osc;
   // open drain only pulls low; high is left to the pull-up
   assign next_oe = drive & (~od | ~value);
   // pull-up only where nothing drives high
   assign next_pu = pu_sel & ~osc & (~dir | od);

   // registered pad controls, undriven after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
         pad_pu  <= 1'b0;
      end else begin
         pad_out <= value;
         pad_oe  <= next_oe;
         pad_pu  <= next_pu;
      end
   end
endmodule
`default_nettype wire

// File: verif/ppc_board_model.sv
// Purpose: board side of the port pins: external drivers and pull-ups
// Assumes: the bench holds its external drive steady until it is read
// Notes:   an undriven pin without pull-up toggles, never holds stale data
`default_nettype none
module ppc_board_model (
   input  wire logic        pclk,
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   input  wire logic [15:0] pin_pu,
   input  wire logic [15:0] ext_val,
   input  wire logic [15:0] ext_oe,
   output var  logic [15:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] flt = 16'h5555;
   // floating level flips so a missing drive cannot pass by luck
   always @(posedge pclk) flt <= ~flt;
   // device drive wins, then board drive, then pull-up
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) |
                   (~pin_oe & ~ext_oe & (pin_pu | flt));
endmodule
`default_nettype wire

// File: verif/ppc_port_ctrl_tb.sv
// Purpose: self-checking bench for the port pin control block
// Assumes: apb accesses finish within a few cycles
// Notes:   pins are checked at the falling edge, after updates land
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ppc_port_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ppc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] pin_in, pin_out, pin_oe, pin_pu, ext_val, ext_oe;
   logic        main_osc_en, sub_osc_en, ext_irq_a, ext_irq_b, ext_irq_f;
   logic        stop_release, two_wire_clock, two_wire_data, pdrv;
   logic        sync_serial_clock, sync_serial_in, uart0_receive, last_err;
   int          err_count, num_checks;
   // route cases: two-wire, sync high, sync low, uart plain, uart swapped
   logic [2:0]  rt [5] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h1};
   logic        sw [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
   logic        od [5] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
   int          pn [5] = '{3, 3, 0, 0, 1};

   ppc_port_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
      .pin_pu, .main_osc_en, .sub_osc_en, .ext_irq_a, .ext_irq_b,
      .ext_irq_f, .stop_release, .two_wire_clock_drv(pdrv),
      .two_wire_data_drv(pdrv), .two_wire_clock, .two_wire_data,
      .sync_serial_clock_drv(pdrv), .sync_serial_clock,
      .sync_serial_out(pdrv), .sync_serial_in, .uart0_transmit(pdrv),
      .uart0_receive);
   ppc_board_model board (.pclk, .pin_out, .pin_oe, .pin_pu, .ext_val,
      .ext_oe, .pin_in);

   always #5 pclk = ~pclk;

   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one apb transfer; pready and read data are taken at the rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) begin
         err_count++;
         report_and_stop();
      end
      q = prdata;
      last_err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'h1, a, d, q);
      @(negedge pclk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'h0, a, 32'h0, q);
      `CHK(q, e)
   endtask

   // main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, pdrv} = 6'h0;
      {paddr, pwdata, ext_val, ext_oe} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      repeat (2) @(negedge pclk);
      `CHK(pin_oe, 16'h0)
      `CHK(main_osc_en, 1'h1)
      rd_chk(OFF_P2_DIR, 32'h0);
      rd_chk(8'h44, 32'h0);
      `CHK(last_err, 1'h1)
      wr(OFF_P2_DATA, 32'ha5);
      wr(OFF_P2_DIR, 32'hff);
      `CHK(pin_out[15:8], 8'ha5)
      `CHK(pin_oe[15:8], 8'hff)
      rd_chk(OFF_P2_DATA, 32'ha5);
      wr(OFF_P2_OD, 32'hff);
      `CHK(pin_oe[15:8], 8'h5a)
      wr(OFF_P2_PU, 32'hff);
      `CHK(pin_pu[15:8], 8'hff)
      wr(OFF_P2_OD, 32'h0);
      `CHK(pin_pu[15:8], 8'h18)
      wr(OFF_P2_DIR, 32'h0);
      @(posedge pclk);
      ext_oe  <= 16'hfff0;
      ext_val <= 16'h3ce0;
      rd_chk(OFF_P2_READ, 32'h3c);
      `CHK(ext_irq_a, 1'h1)
      `CHK(ext_irq_b, 1'h1)
      `CHK(ext_irq_f, 1'h1)
      `CHK(stop_release, 1'h1)
      wr(OFF_P1_DATA, 32'h4);
      wr(OFF_P1_DIR, 32'h4);
      repeat (2) @(negedge pclk);
      `CHK(ext_irq_a, 1'h0)
      `CHK(ext_irq_f, 1'h1)
      wr(OFF_P0_DATA, 32'hf);
      wr(OFF_P0_DIR, 32'hf);
      `CHK(pin_oe[3:0], 4'hc)
      wr(OFF_P0_FC, 32'h4);
      `CHK(pin_oe[3:0], 4'h0)
      @(negedge pclk);
      `CHK(sub_osc_en, 1'h1)
      for (int i = 0; i < 5; i++) begin
         wr(OFF_ROUTE, {29'h0, rt[i]});
         wr(OFF_UART_CFG, {31'h0, sw[i]});
         wr(OFF_P2_FC, 32'h1 << pn[i]);
         wr(OFF_P2_DIR, 32'h1 << pn[i]);
         for (int v = 0; v < 2; v++) begin
            @(posedge pclk);
            pdrv <= v[0];
            ext_val[15:8] <= {8{v[0]}};
            repeat (3) @(negedge pclk);
            `CHK(pin_out[8 + pn[i]], v[0])
            `CHK(pin_oe[8 + pn[i]], ~(od[i] & v[0]))
            `CHK(uart0_receive, rt[i][1] | v[0])
            `CHK(two_wire_clock, rt[i][0] | v[0])
            `CHK(two_wire_data, rt[i][0] | v[0])
            `CHK(sync_serial_clock, (rt[i][0] == rt[i][1]) | v[0])
            `CHK(sync_serial_in, (rt[i][0] == rt[i][1]) | v[0])
         end
      end
      wr(OFF_P2_FC, 32'h0);
      wr(OFF_P2_DIR, 32'hff);
      wr(OFF_P2_DATA, 32'h3c);
      `CHK(pin_out[15:8], 8'h3c)
      `CHK(pin_oe[15:8], 8'hff)
      report_and_stop();
   end
endmodule
`default_nettype wire
